// >>> core/cilt_leaf_table.sv
// Identification leaf table: query port, live sources and overrides
//
// Contract
// - Standard and extended vendor leaves return identical three vendor words.
// - Vendor words hold twelve byte-wide ASCII characters naming the maker.
// - Leaf one and extended leaf one accumulators return the ident register.
// - Effective family is zero-extended low nibble plus eight-bit extension.
// - Effective model is high nibble above low nibble.
// - EBX 31:24 holds initial controller ID, frozen once node number is set.
// - EBX 23:16 is core total plus one when multi-core, else reserved.
// - EBX 15:8 reads 08h flush size; bits 7:0 read 00h brand.
// - EDX bit 28 is one exactly when core total field is nonzero.
// - ECX bit 3 is the inverse of the wait monitor disable control.
// - EDX bit 9 mirrors the interrupt controller enable bit.
// - ECX bit 31 reads zero, left for a hypervisor.
// - Half precision and fused multiply-add flags are one only from C0.
// - ECX bit 27 follows whether the OS enabled state save.
// - Crypto round flag and carry-less multiply flag are product specific.
// - ECX bit 21, extended controller mode, reads zero.
// - Fixed supported flags read one; reserved fields read zero. Here a firmware override of leaf one ECX or EDX can clear the fixed flags.
// - Leaf five EAX and EBX bits 15:0 both read 40h.
// - Leaf five ECX reads one in bits 1 and 0, zero elsewhere.
// - Leaf six ECX reports effective frequency interface present. Here a firmware power override can clear that bit.
// - Leaf seven sub-zero EBX bit-manip flag is one only from C0.
// - Leaf thirteen sub-zero EAX reads 0000_0007h.
// - Leaf thirteen EBX is 512+64, +256 vector or profiling, +128 profiling.
// - Leaf thirteen sub-zero ECX reads 0000_03C0h.
// - Undefined function numbers return zero in all four words.
// - Single-bit feature fields: one means supported, zero not.
`timescale 1ns/100ps
`default_nettype none

module cilt_leaf_table #(
	// Arbitrary neutral maker string, twelve characters, first at the MSB
	parameter logic [95:0] VENDOR_STRING = "NeutralCoreX",
	parameter logic        HAS_CRYPTO    = 1'b1,
	parameter logic        HAS_CARRYLESS = 1'b1
) (
	input  wire logic                   clock,
	input  wire logic                   rst_b,
	// Query port
	input  wire logic                   query_go,
	input  wire logic [31:0]            query_function,
	input  wire logic [31:0]            query_subfunction,
	output logic                        query_done,
	output cilt_pkg::cilt_result_t      query_result,
	// Live sources from the rest of the core
	input  wire logic [31:0]            northbridge_ident_register,
	input  wire logic [7:0]             irq_ctrl_id,
	input  wire logic                   node_number_set,
	input  wire logic [7:0]             core_total_field,
	input  wire logic                   wait_monitor_disable,
	input  wire logic                   irq_ctrl_enable,
	input  wire logic                   os_state_save_enabled,
	input  wire logic                   silicon_c0_or_later,
	input  wire logic                   xcr0_vector,
	input  wire logic                   xcr0_profiling,
	// Firmware override writes
	input  wire logic                   override_write,
	input  wire logic [1:0]             override_select,
	input  wire logic [31:0]            override_data,
	// Decoded identification
	output logic [7:0]                  effective_family,
	output logic [7:0]                  effective_model
);

	localparam logic [31:0] CRYPTO_BIT = {31'h0000_0000, HAS_CRYPTO}
		<< cilt_pkg::ECX_CRYPTO;
	localparam logic [31:0] CARRY_BIT  = {31'h0000_0000, HAS_CARRYLESS}
		<< cilt_pkg::ECX_CARRYLESS;
	localparam logic [31:0] ECX_RESET  = cilt_pkg::ECX_FIXED | CRYPTO_BIT
		| CARRY_BIT;

	logic [31:0]           vendor_b;
	logic [31:0]           vendor_c;
	logic [31:0]           vendor_d;
	logic [31:0]           override_ecx;
	logic [31:0]           override_edx;
	logic [31:0]           override_power;
	logic [7:0]            initial_irq_ctrl_id;
	logic                  multi_core_flag;
	logic [31:0]           feature_flags_c;
	logic [31:0]           feature_flags_d;
	logic [31:0]           apic_id_core_count_flush;
	logic [31:0]           enabled_save_area_size;
	cilt_pkg::cilt_result_t next_result;

	// Vendor words: lowest byte of each word carries the earliest character
	generate
		for (genvar i = 0; i < 4; i++) begin : g_vendor
			assign vendor_b[8*i +: 8] = VENDOR_STRING[95-8*i -: 8];
			assign vendor_d[8*i +: 8] = VENDOR_STRING[63-8*i -: 8];
			assign vendor_c[8*i +: 8] = VENDOR_STRING[31-8*i -: 8];
		end
	endgenerate

	// Firmware overrides; only write-mask positions (fixed flags plus crypto and carry-less) are kept
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			override_ecx   <= ECX_RESET;
			override_edx   <= cilt_pkg::EDX_FIXED;
			override_power <= cilt_pkg::PWR_FIXED;
		end else if (override_write) begin
			unique case (override_select)
				cilt_pkg::OVR_FEAT_C: begin
					override_ecx <= override_data & cilt_pkg::ECX_WRMASK;
				end
				cilt_pkg::OVR_FEAT_D: begin
					override_edx <= override_data & cilt_pkg::EDX_WRMASK;
				end
				cilt_pkg::OVR_POWER: begin
					override_power <= override_data & cilt_pkg::PWR_WRMASK;
				end
				default: begin
				end
			endcase
		end
	end

	// Track the controller ID until the node number is set, then hold it
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			initial_irq_ctrl_id <= 8'h00;
		end else if (!node_number_set) begin
			initial_irq_ctrl_id <= irq_ctrl_id;
		end
	end

	assign multi_core_flag = core_total_field != 8'h00;

	// Dynamic bits are forced; override cannot fake them
	always_comb begin
		feature_flags_c = override_ecx & cilt_pkg::ECX_WRMASK;
		feature_flags_c[cilt_pkg::ECX_GUEST]     = 1'b0;
		feature_flags_c[cilt_pkg::ECX_X_IRQ]     = 1'b0;
		feature_flags_c[cilt_pkg::ECX_HALF_PREC] = silicon_c0_or_later;
		feature_flags_c[cilt_pkg::ECX_FUSED_MA]  = silicon_c0_or_later;
		feature_flags_c[cilt_pkg::ECX_OS_SAVE]   = os_state_save_enabled;
		feature_flags_c[cilt_pkg::ECX_MONITOR]   = ~wait_monitor_disable;
	end

	always_comb begin
		feature_flags_d = override_edx & cilt_pkg::EDX_WRMASK;
		feature_flags_d[cilt_pkg::EDX_MULTI]    = multi_core_flag;
		feature_flags_d[cilt_pkg::EDX_IRQ_CTRL] = irq_ctrl_enable;
	end

	always_comb begin
		apic_id_core_count_flush = 32'h0000_0000;
		apic_id_core_count_flush[cilt_pkg::IRQ_ID_LSB +: 8] =
			initial_irq_ctrl_id;
		apic_id_core_count_flush[cilt_pkg::CORE_TOT_LSB +: 8] =
			multi_core_flag ? 8'(core_total_field + 8'h01) : 8'h00;
		apic_id_core_count_flush[cilt_pkg::FLUSH_LSB +: 8] =
			cilt_pkg::FLUSH_QUADWORDS;
		apic_id_core_count_flush[cilt_pkg::BRAND_LSB +: 8] =
			cilt_pkg::SHORT_BRAND;
	end

	always_comb begin
		enabled_save_area_size = cilt_pkg::AREA_LEGACY
			+ cilt_pkg::AREA_HEADER;
		if (xcr0_vector || xcr0_profiling) begin
			enabled_save_area_size = enabled_save_area_size
				+ cilt_pkg::AREA_VECTOR;
		end
		if (xcr0_profiling) begin
			enabled_save_area_size = enabled_save_area_size
				+ cilt_pkg::AREA_PROFILE;
		end
	end

	// Leaf decode; anything not listed answers all zero
	always_comb begin
		next_result = '0;
		unique case (query_function)
			cilt_pkg::FN_VENDOR: begin
				next_result.eax = cilt_pkg::LARGEST_STD;
				next_result.ebx = vendor_b;
				next_result.ecx = vendor_c;
				next_result.edx = vendor_d;
			end
			cilt_pkg::FN_EXT_VENDOR: begin
				next_result.eax = cilt_pkg::LARGEST_EXT;
				next_result.ebx = vendor_b;
				next_result.ecx = vendor_c;
				next_result.edx = vendor_d;
			end
			cilt_pkg::FN_FEATURES: begin
				next_result.eax = northbridge_ident_register;
				next_result.ebx = apic_id_core_count_flush;
				next_result.ecx = feature_flags_c;
				next_result.edx = feature_flags_d;
			end
			cilt_pkg::FN_EXT_FEAT: begin
				next_result.eax = northbridge_ident_register;
			end
			cilt_pkg::FN_MONITOR: begin
				next_result.eax = cilt_pkg::WATCH_LINE;
				next_result.ebx = cilt_pkg::WATCH_LINE;
				next_result.ecx = cilt_pkg::WAIT_FLAGS;
			end
			cilt_pkg::FN_POWER: begin
				next_result.ecx = override_power & cilt_pkg::PWR_WRMASK;
			end
			cilt_pkg::FN_STRUCT: begin
				if (query_subfunction == cilt_pkg::SUBFN_ZERO) begin
					next_result.ebx[cilt_pkg::BIT_MANIP] =
						silicon_c0_or_later;
				end
			end
			cilt_pkg::FN_EXT_STATE: begin
				if (query_subfunction == cilt_pkg::SUBFN_ZERO) begin
					next_result.eax = cilt_pkg::STATE_MASK;
					next_result.ebx = enabled_save_area_size;
					next_result.ecx = cilt_pkg::AREA_FULL;
				end
			end
			default: begin
				next_result = '0;
			end
		endcase
	end

	// Answer one cycle after the request; held until the next one
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			query_result <= '0;
		end else if (query_go) begin
			query_result <= next_result;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			query_done <= 1'b0;
		end else begin
			query_done <= query_go;
		end
	end

	// Decoded identification follows the ident register by one cycle
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			effective_family <= 8'h00;
			effective_model  <= 8'h00;
		end else begin
			effective_family <= 8'({4'h0,
				northbridge_ident_register[cilt_pkg::FAM_LOW_LSB +: 4]}
				+ northbridge_ident_register[cilt_pkg::FAM_EXT_LSB +: 8]);
			effective_model <= {
				northbridge_ident_register[cilt_pkg::MOD_HIGH_LSB +: 4],
				northbridge_ident_register[cilt_pkg::MOD_LOW_LSB +: 4]};
		end
	end

	vendor_same_a: assert property (@(posedge clock) disable iff (!rst_b)
		query_go && (query_function == cilt_pkg::FN_VENDOR
		|| query_function == cilt_pkg::FN_EXT_VENDOR)
		|=> query_done && query_result.ebx == vendor_b
		&& query_result.ecx == vendor_c && query_result.edx == vendor_d)
		else $error("vendor words differ");

	vendor_ascii_a: assert property (@(posedge clock) disable iff (!rst_b)
		query_done && $past(query_function) == cilt_pkg::FN_VENDOR
		|-> {query_result.ebx[7:0], query_result.ebx[31:24]}
		== {VENDOR_STRING[95:88], VENDOR_STRING[71:64]})
		else $error("vendor byte order wrong");

	ident_alias_a: assert property (@(posedge clock) disable iff (!rst_b)
		query_go && query_function == cilt_pkg::FN_EXT_FEAT
		|=> query_result.eax == $past(northbridge_ident_register))
		else $error("ident alias wrong");

	// Start only out of reset: the release edge loads nothing
	family_sum_a: assert property (@(posedge clock) disable iff (!rst_b)
		rst_b |=> effective_family
		== 8'($past(northbridge_ident_register[11:8])
		+ $past(northbridge_ident_register[27:20])))
		else $error("family sum wrong");

	model_join_a: assert property (@(posedge clock) disable iff (!rst_b)
		rst_b |=> effective_model
		== {$past(northbridge_ident_register[19:16]),
		$past(northbridge_ident_register[7:4])})
		else $error("model join wrong");

	id_frozen_a: assert property (@(posedge clock) disable iff (!rst_b)
		node_number_set ##1 node_number_set
		|-> $stable(initial_irq_ctrl_id))
		else $error("initial id changed after node set");

	core_count_a: assert property (@(posedge clock) disable iff (!rst_b)
		query_go && query_function == cilt_pkg::FN_FEATURES
		|=> query_result.ebx[23:16] == ($past(core_total_field) != 8'h00
		? 8'($past(core_total_field) + 8'h01) : 8'h00)
		&& query_result.edx[28] == ($past(core_total_field) != 8'h00))
		else $error("core count or multi-core flag wrong");

	flush_brand_a: assert property (@(posedge clock) disable iff (!rst_b)
		query_go && query_function == cilt_pkg::FN_FEATURES
		|=> query_result.ebx[15:0] == 16'h0800)
		else $error("flush size or brand wrong");

	dynamic_bits_a: assert property (@(posedge clock) disable iff (!rst_b)
		query_go && query_function == cilt_pkg::FN_FEATURES
		|=> query_result.ecx[3] == !$past(wait_monitor_disable)
		&& query_result.edx[9] == $past(irq_ctrl_enable)
		&& query_result.ecx[27] == $past(os_state_save_enabled)
		&& !query_result.ecx[31] && !query_result.ecx[21])
		else $error("dynamic feature bit wrong");

	revision_bits_a: assert property (@(posedge clock) disable iff (!rst_b)
		query_go && query_function == cilt_pkg::FN_FEATURES
		|=> query_result.ecx[29] == $past(silicon_c0_or_later)
		&& query_result.ecx[12] == $past(silicon_c0_or_later))
		else $error("revision gated flag wrong");

	reserved_zero_a: assert property (@(posedge clock) disable iff (!rst_b)
		query_done && $past(query_function) == cilt_pkg::FN_FEATURES
		|-> (query_result.ecx & ~cilt_pkg::ECX_WRMASK & 32'hD7FF_EFF7)
		== 32'h0000_0000
		&& (query_result.edx & 32'hE874_0400) == 32'h0000_0000)
		else $error("reserved feature bits set");

	monitor_leaf_a: assert property (@(posedge clock) disable iff (!rst_b)
		query_go && query_function == cilt_pkg::FN_MONITOR
		|=> query_result.eax == 32'h0000_0040
		&& query_result.ebx == 32'h0000_0040
		&& query_result.ecx == 32'h0000_0003)
		else $error("monitor leaf wrong");

	save_size_a: assert property (@(posedge clock) disable iff (!rst_b)
		query_go && query_function == cilt_pkg::FN_EXT_STATE
		&& query_subfunction == cilt_pkg::SUBFN_ZERO
		|=> query_result.ebx == 32'h0000_0240
		+ (($past(xcr0_vector) || $past(xcr0_profiling)) ? 32'h0000_0100
		: 32'h0000_0000)
		+ ($past(xcr0_profiling) ? 32'h0000_0080 : 32'h0000_0000)
		&& query_result.eax == 32'h0000_0007
		&& query_result.ecx == 32'h0000_03C0)
		else $error("extended state leaf wrong");

	undefined_zero_a: assert property (@(posedge clock) disable iff (!rst_b)
		query_go && (query_function == cilt_pkg::FN_RSVD_2
		|| query_function == 32'h8000_0002
		|| query_function == 32'h0000_000E)
		|=> query_result == '0)
		else $error("undefined leaf not zero");

	struct_leaf_a: assert property (@(posedge clock) disable iff (!rst_b)
		query_go && query_function == cilt_pkg::FN_STRUCT
		|=> query_result.ebx == (($past(query_subfunction) == 32'h0000_0000)
		? {28'h000_0000, $past(silicon_c0_or_later), 3'h0} : 32'h0000_0000)
		&& query_result.eax == 32'h0000_0000
		&& query_result.ecx == 32'h0000_0000
		&& query_result.edx == 32'h0000_0000)
		else $error("structured leaf wrong");

	// Only sub-function zero is enumerated; the rest must stay silent
	sub_zero_a: assert property (@(posedge clock) disable iff (!rst_b)
		query_go && query_function == cilt_pkg::FN_EXT_STATE
		&& query_subfunction != cilt_pkg::SUBFN_ZERO
		|=> query_result == '0)
		else $error("extended state sub-function not zero");

	ext_ident_a: assert property (@(posedge clock) disable iff (!rst_b)
		query_go && query_function == cilt_pkg::FN_EXT_FEAT
		|=> query_result.ebx == 32'h0000_0000
		&& query_result.ecx == 32'h0000_0000
		&& query_result.edx == 32'h0000_0000)
		else $error("extended leaf one extra words set");

	power_leaf_a: assert property (@(posedge clock) disable iff (!rst_b)
		override_write && override_select == cilt_pkg::OVR_POWER
		##1 query_go && query_function == cilt_pkg::FN_POWER
		|=> query_result.ecx == {31'h0000_0000, $past(override_data[0], 2)})
		else $error("power override not reflected");

	answer_hold_a: assert property (@(posedge clock) disable iff (!rst_b)
		!query_go |=> $stable(query_result) && !query_done)
		else $error("result moved without a query");

endmodule : cilt_leaf_table

`default_nettype wire

// >>> core/cilt_pkg.sv
// Constants and types for the identification leaf table
package cilt_pkg;

	// Four result words of one query
	typedef struct packed {
		logic [31:0] eax;
		logic [31:0] ebx;
		logic [31:0] ecx;
		logic [31:0] edx;
	} cilt_result_t;

	// Function numbers
	localparam logic [31:0] FN_VENDOR      = 32'h0000_0000;
	localparam logic [31:0] FN_FEATURES    = 32'h0000_0001;
	localparam logic [31:0] FN_RSVD_2      = 32'h0000_0002;
	localparam logic [31:0] FN_RSVD_4      = 32'h0000_0004;
	localparam logic [31:0] FN_MONITOR     = 32'h0000_0005;
	localparam logic [31:0] FN_POWER       = 32'h0000_0006;
	localparam logic [31:0] FN_STRUCT      = 32'h0000_0007;
	localparam logic [31:0] FN_RSVD_8      = 32'h0000_0008;
	localparam logic [31:0] FN_RSVD_C      = 32'h0000_000C;
	localparam logic [31:0] FN_EXT_STATE   = 32'h0000_000D;
	localparam logic [31:0] FN_EXT_VENDOR  = 32'h8000_0000;
	localparam logic [31:0] FN_EXT_FEAT    = 32'h8000_0001;
	localparam logic [31:0] SUBFN_ZERO     = 32'h0000_0000;

	// Largest function numbers reported in the accumulator
	localparam logic [31:0] LARGEST_STD    = 32'h0000_000D;
	localparam logic [31:0] LARGEST_EXT    = 32'h8000_001E;

	// Family and model field positions in the ident register
	localparam int FAM_LOW_LSB   = 8;
	localparam int FAM_EXT_LSB   = 20;
	localparam int MOD_LOW_LSB   = 4;
	localparam int MOD_HIGH_LSB  = 16;

	// Leaf one EBX fields
	localparam int  IRQ_ID_LSB     = 24;
	localparam int  CORE_TOT_LSB   = 16;
	localparam int  FLUSH_LSB      = 8;
	localparam int  BRAND_LSB      = 0;
	localparam logic [7:0] FLUSH_QUADWORDS = 8'h08;
	localparam logic [7:0] SHORT_BRAND     = 8'h00;

	// Leaf one ECX bit positions
	localparam int ECX_GUEST     = 31;
	localparam int ECX_HALF_PREC = 29;
	localparam int ECX_OS_SAVE   = 27;
	localparam int ECX_CRYPTO    = 25;
	localparam int ECX_X_IRQ     = 21;
	localparam int ECX_FUSED_MA  = 12;
	localparam int ECX_MONITOR   = 3;
	localparam int ECX_CARRYLESS = 1;

	// Leaf one EDX bit positions
	localparam int EDX_MULTI     = 28;
	localparam int EDX_IRQ_CTRL  = 9;

	// Fixed feature values and the bits an override may change
	localparam logic [31:0] ECX_FIXED   = 32'h1498_2201;
	localparam logic [31:0] ECX_WRMASK  = 32'h1698_2203;
	localparam logic [31:0] EDX_FIXED   = 32'h078B_F9FF;
	localparam logic [31:0] EDX_WRMASK  = 32'h078B_F9FF;
	localparam logic [31:0] PWR_FIXED   = 32'h0000_0001;
	localparam logic [31:0] PWR_WRMASK  = 32'h0000_0001;

	// Override register selects
	localparam logic [1:0] OVR_FEAT_C = 2'h0;
	localparam logic [1:0] OVR_FEAT_D = 2'h1;
	localparam logic [1:0] OVR_POWER  = 2'h2;

	// Monitor leaf and structured leaf
	localparam logic [31:0] WATCH_LINE   = 32'h0000_0040;
	localparam logic [31:0] WAIT_FLAGS   = 32'h0000_0003;
	localparam int          BIT_MANIP    = 3;

	// Extended state leaf, sub-function zero
	localparam logic [31:0] STATE_MASK   = 32'h0000_0007;
	localparam logic [31:0] AREA_LEGACY  = 32'h0000_0200;
	localparam logic [31:0] AREA_HEADER  = 32'h0000_0040;
	localparam logic [31:0] AREA_VECTOR  = 32'h0000_0100;
	localparam logic [31:0] AREA_PROFILE = 32'h0000_0080;
	localparam logic [31:0] AREA_FULL    = 32'h0000_03C0;

endpackage : cilt_pkg

// >>> testbench/cilt_leaf_table_bench.sv
// Self-checking bench for the identification leaf table
`timescale 1ns/100ps
`default_nettype none

module cilt_leaf_table_bench;

	// Arbitrary neutral maker string for this build
	localparam logic [95:0] VS = "BenchMakerQx";
	localparam logic        HC = 1'b0;
	localparam logic        HL = 1'b1;

	logic                   clock;
	logic                   rst_b;
	logic                   query_go;
	logic [31:0]            query_function;
	logic [31:0]            query_subfunction;
	logic                   query_done;
	cilt_pkg::cilt_result_t query_result;
	logic [31:0]            northbridge_ident_register;
	logic [7:0]             irq_ctrl_id;
	logic                   node_number_set;
	logic [7:0]             core_total_field;
	logic                   wait_monitor_disable;
	logic                   irq_ctrl_enable;
	logic                   os_state_save_enabled;
	logic                   silicon_c0_or_later;
	logic                   xcr0_vector;
	logic                   xcr0_profiling;
	logic                   override_write;
	logic [1:0]             override_select;
	logic [31:0]            override_data;
	logic [7:0]             effective_family;
	logic [7:0]             effective_model;
	int                     err_count;
	int                     n_checks;
	logic [31:0]            seed;
	logic [31:0]            ovr_c, ovr_d, ovr_p;
	logic [31:0]            prev_ident;
	logic [7:0]             id_copy;
	logic                   pending, fam_valid;
	logic                   rst_seen;
	cilt_pkg::cilt_result_t expected;

	cilt_leaf_table #(.VENDOR_STRING(VS), .HAS_CRYPTO(HC), .HAS_CARRYLESS(HL))
	u_cilt_leaf_table (
		.clock(clock), .rst_b(rst_b), .query_go(query_go),
		.query_function(query_function), .query_subfunction(query_subfunction),
		.query_done(query_done), .query_result(query_result),
		.northbridge_ident_register(northbridge_ident_register),
		.irq_ctrl_id(irq_ctrl_id), .node_number_set(node_number_set),
		.core_total_field(core_total_field),
		.wait_monitor_disable(wait_monitor_disable),
		.irq_ctrl_enable(irq_ctrl_enable),
		.os_state_save_enabled(os_state_save_enabled),
		.silicon_c0_or_later(silicon_c0_or_later),
		.xcr0_vector(xcr0_vector), .xcr0_profiling(xcr0_profiling),
		.override_write(override_write), .override_select(override_select),
		.override_data(override_data), .effective_family(effective_family),
		.effective_model(effective_model)
	);

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd

	// Word i of the vendor string, first character in the low byte
	function automatic logic [31:0] vw(input int i);
		logic [31:0] w;
		for (int k = 0; k < 4; k++)
			w[8*k +: 8] = VS[95-8*(4*i+k) -: 8];
		return w;
	endfunction : vw

	// Reference answer from the live inputs and the model's own state
	function automatic cilt_pkg::cilt_result_t model(input logic [31:0] f,
		input logic [31:0] s);
		cilt_pkg::cilt_result_t r;
		logic [7:0] n;
		r = '0;
		n = (core_total_field != 8'h00) ? core_total_field + 8'h01 : 8'h00;
		case (f)
			32'h0000_0000, 32'h8000_0000: begin
				r.eax = f[31] ? 32'h8000_001E : 32'h0000_000D;
				r.ebx = vw(0);
				r.edx = vw(1);
				r.ecx = vw(2);
			end
			32'h0000_0001: begin
				r.eax = northbridge_ident_register;
				r.ebx = {id_copy, n, 8'h08, 8'h00};
				r.ecx = ovr_c & cilt_pkg::ECX_WRMASK;
				r.ecx[29] = silicon_c0_or_later;
				r.ecx[12] = silicon_c0_or_later;
				r.ecx[27] = os_state_save_enabled;
				r.ecx[3] = !wait_monitor_disable;
				r.edx = ovr_d & cilt_pkg::EDX_WRMASK;
				r.edx[28] = core_total_field != 8'h00;
				r.edx[9] = irq_ctrl_enable;
			end
			32'h8000_0001: r.eax = northbridge_ident_register;
			32'h0000_0005: begin
				r.eax = 32'h0000_0040;
				r.ebx = 32'h0000_0040;
				r.ecx = 32'h0000_0003;
			end
			32'h0000_0006: r.ecx = ovr_p & 32'h0000_0001;
			32'h0000_0007: if (s == '0) r.ebx[3] = silicon_c0_or_later;
			32'h0000_000D: if (s == '0) begin
				r.eax = 32'h0000_0007;
				r.ebx = 32'h0000_0240
					+ ((xcr0_vector | xcr0_profiling) ? 32'h0000_0100 : '0)
					+ (xcr0_profiling ? 32'h0000_0080 : '0);
				r.ecx = 32'h0000_03C0;
			end
			default: r = '0;
		endcase
		return r;
	endfunction : model

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic end_of_test();
		if (err_count == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : end_of_test

	// Monitor sees pre-edge values, the same ones the design samples
	always @(posedge clock) begin
		if (!rst_b) begin
			// The first edge may come before the reset has taken hold
			if (rst_seen) begin
				for (int i = 0; i < 4; i++)
					check(query_result[32*i +: 32], '0);
				check(32'(query_done), '0);
				check(32'({effective_family, effective_model}), '0);
			end
			rst_seen = 1'b1;
			pending = 1'b0;
			fam_valid = 1'b0;
			id_copy = 8'h00;
			ovr_c = cilt_pkg::ECX_FIXED | {6'h0, HC, 23'h0, HL, 1'b0};
			ovr_d = cilt_pkg::EDX_FIXED;
			ovr_p = cilt_pkg::PWR_FIXED;
		end else begin
			check(32'(query_done), 32'(pending));
			if (pending) begin
				check(query_result.eax, expected.eax);
				check(query_result.ebx, expected.ebx);
				check(query_result.ecx, expected.ecx);
				check(query_result.edx, expected.edx);
			end
			if (fam_valid) begin
				check(32'(effective_family),
					32'(8'({4'h0, prev_ident[11:8]} + prev_ident[27:20])));
				check(32'(effective_model),
					32'({prev_ident[19:16], prev_ident[7:4]}));
			end
			prev_ident = northbridge_ident_register;
			fam_valid = 1'b1;
			pending = query_go;
			if (query_go)
				expected = model(query_function, query_subfunction);
			if (!node_number_set)
				id_copy = irq_ctrl_id;
			if (override_write) begin
				case (override_select)
					2'h0: ovr_c = override_data;
					2'h1: ovr_d = override_data;
					2'h2: ovr_p = override_data;
					default: ;
				endcase
			end
		end
	end

	// ID and node flag move only on idle cycles, so a query never races them
	task automatic run(input int cycles);
		logic [31:0] a, b, c;
		repeat (cycles) begin
			@(posedge clock);
			a = rnd();
			b = rnd();
			c = rnd();
			query_go <= a[0] | a[1];
			query_function <= (a[30:28] == 3'h0) ? b : {a[31], 27'h0, a[5:2]};
			query_subfunction <= {30'h0, a[7:6]};
			northbridge_ident_register <= b;
			core_total_field <= c[7:0] & {8{c[8]}};
			{wait_monitor_disable, irq_ctrl_enable, os_state_save_enabled,
				silicon_c0_or_later, xcr0_vector, xcr0_profiling} <= c[14:9];
			override_write <= c[15] & c[16];
			override_select <= c[18:17];
			override_data <= b ^ c;
			if (!(a[0] | a[1])) begin
				irq_ctrl_id <= c[26:19];
				node_number_set <= node_number_set ^ (c[31:28] == 4'h0);
			end
		end
	endtask : run

	initial begin
		err_count = 0;
		n_checks = 0;
		rst_seen = 1'b0;
		seed = 32'h0000_BADC;
		rst_b = 1'b0;
		query_go = 1'b0;
		query_function = '0;
		query_subfunction = '0;
		northbridge_ident_register = '0;
		irq_ctrl_id = 8'h00;
		node_number_set = 1'b0;
		core_total_field = 8'h00;
		{wait_monitor_disable, irq_ctrl_enable, os_state_save_enabled,
			silicon_c0_or_later, xcr0_vector, xcr0_profiling} = 6'h00;
		override_write = 1'b0;
		override_select = 2'h0;
		override_data = '0;
		repeat (3) @(posedge clock);
		rst_b <= 1'b1;
		run(3000);
		// Second reset mid-run must restore override defaults; the port is
		// left idle so no request stands at the release edge
		@(posedge clock);
		query_go <= 1'b0;
		override_write <= 1'b0;
		rst_b <= 1'b0;
		repeat (3) @(posedge clock);
		rst_b <= 1'b1;
		run(3000);
		end_of_test();
	end

	initial begin
		#200000;
		err_count++;
		end_of_test();
	end

endmodule : cilt_leaf_table_bench

`default_nettype wire
